// >>> logic/tsd_pkg.sv
package tsd_pkg;

  // ----------------------------------------
  // Timing and limits
  // ----------------------------------------
  localparam int MC_DIV_DEF = 4;
  localparam logic [1:0] SKIP_MC_1B = 2'h1;
  localparam logic [1:0] SKIP_MC_2B = 2'h2;
  localparam logic [1:0] SKIP_MC_TREF = 2'h1;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [6:0] TBL_LO = 7'h20;
  localparam logic [13:0] ADDR_MAX = 14'h3f7f;
  localparam logic [7:0] FMEM_FB = 8'hfb;
  localparam logic [7:0] FMEM_FF = 8'hff;
  localparam logic [5:0] PMEM_TOP = 6'h3f;
  localparam logic [3:0] BANK_ZERO = 4'h0;

  // ----------------------------------------
  // Opcode layout
  // ----------------------------------------
  localparam logic [3:0] OPM_LD_A4 = 4'h8;
  localparam logic [3:0] OPM_PTR = 4'h9;
  localparam logic [3:0] OPM_STEP = 4'ha;
  localparam logic [3:0] OPM_2B = 4'hb;
  localparam logic [3:0] OPM_ADD_SKIP = 4'hc;
  localparam logic [3:0] OPM_CARRY = 4'hd;
  localparam logic [3:0] OPM_CALL_BLK = 4'he;
  localparam logic [3:0] OPM_MISC = 4'hf;
  localparam logic [3:0] SUB_XA8 = 4'h0;
  localparam logic [3:0] SUB_HL8 = 4'h1;
  localparam logic [3:0] SUB_MEM8 = 4'h2;
  localparam logic [3:0] SUB_XPAIR = 4'h3;
  localparam logic [1:0] BM_FB = 2'h0;
  localparam logic [1:0] BM_PL = 2'h1;
  localparam logic [1:0] BM_H = 2'h2;
  localparam logic [1:0] BM_FF = 2'h3;
  localparam logic [1:0] PP_HL = 2'h0;
  localparam logic [1:0] PP_DE = 2'h1;
  localparam logic [1:0] PP_DL = 2'h2;
  localparam logic [2:0] TG_L = 3'h0;
  localparam logic [2:0] TG_H = 3'h1;
  localparam logic [2:0] TG_HL = 3'h2;
  localparam logic [2:0] TG_E = 3'h3;
  localparam logic [2:0] TG_D = 3'h4;
  localparam logic [2:0] TG_DE = 3'h5;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [4:0] {
    CL_OTHER, CL_TREF, CL_LD_A4, CL_LD_XA8, CL_LD_HL8, CL_PTR_MOV, CL_PTR_STEP,
    CL_ADD_SKIP, CL_ADD_CARRY, CL_SUB_CARRY, CL_MEM8, CL_XPAIR, CL_CALL_BLK,
    CL_CALL_FAST, CL_BIT, CL_BRANCH, CL_CALL
  } tsd_cls_t;

  typedef enum logic [1:0] {GRP_NONE, GRP_A, GRP_B} tsd_grp_t;

  typedef struct packed {
    tsd_cls_t cls;
    logic two_byte;
    logic [1:0] cyc;
    tsd_grp_t grp;
    logic skip_fn;
    logic [1:0] pair;
    logic [2:0] tgt;
  } tsd_dec_t;

  typedef struct packed {
    tsd_cls_t cls;
    logic [15:0] op;
    logic skip_en;
    logic keep_carry;
    logic from_table;
    logic [2:0] bit_fn;
    logic [11:0] bit_addr;
    logic [1:0] bit_num;
    logic [2:0] pair_sel;
    logic [13:0] target;
  } tsd_exop_t;

endpackage

// >>> logic/tsd_classify.sv
`timescale 1ns/1ps
`default_nettype none

module tsd_classify #(
  parameter bit IS_ENTRY = 1'b0
) (
  // Instruction word, first byte high
  input wire logic [15:0] word,
  // Decoded attributes
  output tsd_pkg::tsd_dec_t dec
);

  always_comb begin
    dec = '0;
    dec.cyc = tsd_pkg::CYC_ONE;
    case (word[15:12])
      // RQ9 stacking groups
      tsd_pkg::OPM_LD_A4: begin
        dec.cls = tsd_pkg::CL_LD_A4;
        dec.grp = tsd_pkg::GRP_A;
      end
      tsd_pkg::OPM_PTR: begin
        dec.cls = (word[9:8] == 2'h3) ? tsd_pkg::CL_OTHER : tsd_pkg::CL_PTR_MOV;
        dec.pair = word[9:8];
      end
      tsd_pkg::OPM_STEP: begin
        dec.cls = tsd_pkg::CL_PTR_STEP;
        dec.tgt = word[10:8];
        dec.skip_fn = 1'b1;
      end
      tsd_pkg::OPM_2B: begin
        dec.two_byte = 1'b1;
        dec.cyc = tsd_pkg::CYC_TWO;
        case (word[11:8])
          tsd_pkg::SUB_XA8: begin
            dec.cls = tsd_pkg::CL_LD_XA8;
            dec.grp = tsd_pkg::GRP_A;
          end
          tsd_pkg::SUB_HL8: begin
            dec.cls = tsd_pkg::CL_LD_HL8;
            dec.grp = tsd_pkg::GRP_B;
          end
          tsd_pkg::SUB_MEM8: dec.cls = tsd_pkg::CL_MEM8;
          tsd_pkg::SUB_XPAIR: dec.cls = tsd_pkg::CL_XPAIR;
          default: dec.cls = tsd_pkg::CL_OTHER;
        endcase
      end
      tsd_pkg::OPM_ADD_SKIP: begin
        dec.cls = tsd_pkg::CL_ADD_SKIP;
        dec.skip_fn = 1'b1;
      end
      tsd_pkg::OPM_CARRY: begin
        dec.cls = word[8] ? tsd_pkg::CL_SUB_CARRY : tsd_pkg::CL_ADD_CARRY;
      end
      tsd_pkg::OPM_CALL_BLK: begin
        dec.cls = tsd_pkg::CL_CALL_BLK;
        dec.two_byte = 1'b1;
        dec.cyc = tsd_pkg::CYC_THREE;
      end
      tsd_pkg::OPM_MISC: begin
        dec.two_byte = 1'b1;
        dec.cls = word[11] ? tsd_pkg::CL_BIT : tsd_pkg::CL_CALL_FAST;
        dec.cyc = word[11] ? tsd_pkg::CYC_TWO : tsd_pkg::CYC_THREE;
        dec.skip_fn = word[11];
      end
      default: begin
        if (IS_ENTRY) begin
          dec.cls = word[14] ? tsd_pkg::CL_CALL : tsd_pkg::CL_BRANCH;
          dec.two_byte = 1'b1;
          dec.cyc = tsd_pkg::CYC_TWO;
        // RQ16 even table address
        end else if (!word[8] && word[14:8] >= tsd_pkg::TBL_LO) begin
          dec.cls = tsd_pkg::CL_TREF;
        end else begin
          dec.cls = tsd_pkg::CL_OTHER;
        end
      end
    endcase
  end

endmodule // tsd_classify

`default_nettype wire

// >>> logic/tsd_table_ref_decode.sv
//
// Contract
// RQ1 - Two-byte table entries must be two-machine-cycle instructions.
// RQ2 - Paired entry: pointer move or exchange, then step of that pointer.
// RQ3 - Program counter advances only past the table-reference byte itself.
// RQ4 - A pending skip skips the table-reference like any one-byte instruction.
// RQ5 - A taken skip in the referenced instruction skips the next instruction.
// RQ6 - Same group before the table-reference: stacking cancelled, entry executes.
// RQ7 - Same group after the table-reference: stacking holds, that one is skipped.
// RQ8 - In a run of same-group immediate loads only the first executes.
// RQ9 - Group A: 4-bit and 8-bit accumulator loads; group B: pointer load.
// RQ10 - Final add-then-skip of a radix sequence never skips, carry kept.
// RQ11 - Radix sequences: add, add-with-carry or sub-with-carry, then add-then-skip; the code counts only add-with-carry or sub-with-carry as the lead-in.
// RQ12 - Bit ops: set, clear, test, carry transfers, and, or, xor.
// RQ13 - Fixed bit operand reaches FB0H-FBFH and FF0H-FFFH in bank 15.
// RQ14 - Low-register bit operand reaches FC0H-FFFH, bit chosen by low register.
// RQ15 - High-relative bit operand uses the currently selected memory bank.
// RQ16 - Table address from 20H to 7FH and always even.
// RQ17 - Eight-bit memory operands must be even addresses.
// RQ18 - Targets up to 3F7FH; in-block call 12 bits; fast call 11 bits.
// RQ19 - Bit number is a 2-bit field choosing one of four bits.
// RQ20 - Extended pair operand selects one of eight register pairs.
// RQ21 - Skipping the table-reference takes one machine cycle.
// RQ22 - Table-reference reads a two-byte entry at the even table address.
// RQ23 - The stacking group of the last executed instruction is remembered.
`timescale 1ns/1ps
`default_nettype none

module tsd_table_ref_decode #(
  parameter int MC_DIV = tsd_pkg::MC_DIV_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction stream
  input wire logic ins_valid,
  input wire logic [15:0] ins_word,
  input wire logic [13:0] ins_pc,
  output logic ins_ready,
  // Table entry read
  output logic tbl_req,
  output logic [6:0] tbl_addr,
  input wire logic tbl_ack,
  input wire logic [15:0] tbl_word,
  // Execution unit
  output logic ex_valid,
  output tsd_pkg::tsd_exop_t ex_op,
  input wire logic ex_done,
  input wire logic ex_cond,
  // Core state
  input wire logic bank_enable_flag,
  input wire logic [3:0] bank_select_reg,
  input wire logic [3:0] l_reg,
  input wire logic [3:0] h_reg,
  // Sequencing
  output logic pc_step_valid,
  output logic [1:0] pc_step_bytes,
  output logic op_error
);

  typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_TREAD, ST_EXEC} tsd_state_t;

  tsd_state_t state_reg;
  tsd_pkg::tsd_dec_t cur_dec;
  tsd_pkg::tsd_dec_t ent_dec;
  tsd_pkg::tsd_dec_t two_dec;
  tsd_pkg::tsd_exop_t ex_op_reg;
  tsd_pkg::tsd_exop_t op2_reg;
  tsd_pkg::tsd_grp_t last_grp_reg;
  tsd_pkg::tsd_cls_t prev_cls_reg;
  logic [7:0] div_reg;
  logic mc_tick_reg;
  logic ins_ready_reg;
  logic skip_pend_reg;
  logic [1:0] skip_left_reg;
  logic in_tref_reg;
  logic pend2_reg;
  logic [1:0] pair1_reg;
  logic [1:0] step_bytes_reg;
  logic tbl_req_reg;
  logic [6:0] tbl_addr_reg;
  logic ex_valid_reg;
  logic pc_step_valid_reg;
  logic [1:0] pc_step_bytes_reg;
  logic op_error_reg;
  logic take;
  logic stacked;
  logic radix_cur;
  logic radix_ent;
  logic cur_bad;
  logic ent_bad;
  logic ent_xfer;

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  tsd_classify #(.IS_ENTRY(1'b0)) u_cur (.word(ins_word), .dec(cur_dec));
  tsd_classify #(.IS_ENTRY(1'b1)) u_ent (.word(tbl_word), .dec(ent_dec));
  tsd_classify #(.IS_ENTRY(1'b0)) u_two (.word({tbl_word[7:0], 8'h00}), .dec(two_dec));

  function automatic logic pair_ok(input logic [1:0] p, input logic [2:0] t);
    case (p)
      tsd_pkg::PP_HL: pair_ok = (t == tsd_pkg::TG_L) || (t == tsd_pkg::TG_H)
                                || (t == tsd_pkg::TG_HL);
      tsd_pkg::PP_DE: pair_ok = (t == tsd_pkg::TG_E) || (t == tsd_pkg::TG_D)
                                || (t == tsd_pkg::TG_DE);
      tsd_pkg::PP_DL: pair_ok = (t == tsd_pkg::TG_L) || (t == tsd_pkg::TG_D);
      default: pair_ok = 1'b0;
    endcase
  endfunction

  function automatic tsd_pkg::tsd_exop_t make_op(input tsd_pkg::tsd_dec_t d,
                                                 input logic [15:0] w, input logic tbl,
                                                 input logic rdx);
    tsd_pkg::tsd_exop_t o;
    logic [3:0] bank;
    o = '0;
    bank = bank_enable_flag ? bank_select_reg : tsd_pkg::BANK_ZERO;
    o.cls = d.cls;
    o.op = w;
    o.from_table = tbl;
    // RQ10 skip disabled, carry kept
    o.skip_en = d.skip_fn && !rdx;
    o.keep_carry = rdx;
    // RQ12 bit function field
    o.bit_fn = w[10:8];
    // RQ19 two-bit bit number
    o.bit_num = w[5:4];
    // RQ20 eight extended pairs
    o.pair_sel = w[2:0];
    case (w[7:6])
      // RQ13 fixed bit window
      tsd_pkg::BM_FB: o.bit_addr = {tsd_pkg::FMEM_FB, w[3:0]};
      tsd_pkg::BM_FF: o.bit_addr = {tsd_pkg::FMEM_FF, w[3:0]};
      // RQ14 low-register indexed bit
      tsd_pkg::BM_PL: begin
        o.bit_addr = {tsd_pkg::PMEM_TOP, w[3:0], l_reg[3:2]};
        o.bit_num = l_reg[1:0];
      end
      // RQ15 selected bank
      default: o.bit_addr = {bank, h_reg, w[3:0]};
    endcase
    // RQ18 target widths
    case (d.cls)
      tsd_pkg::CL_CALL_BLK: o.target = {ins_pc[13:12], w[11:0]};
      tsd_pkg::CL_CALL_FAST: o.target = {3'h0, w[10:0]};
      default: o.target = w[13:0];
    endcase
    return o;
  endfunction

  // ----------------------------------------
  // Classification terms
  // ----------------------------------------
  assign take = (state_reg == ST_IDLE) && ins_ready_reg && ins_valid;
  // RQ8 repeated group load
  assign stacked = (cur_dec.grp != tsd_pkg::GRP_NONE) && (cur_dec.grp == last_grp_reg);
  // RQ11 radix sequence tail
  assign radix_cur = (cur_dec.cls == tsd_pkg::CL_ADD_SKIP)
                     && ((prev_cls_reg == tsd_pkg::CL_ADD_CARRY)
                     || (prev_cls_reg == tsd_pkg::CL_SUB_CARRY));
  assign radix_ent = (ent_dec.cls == tsd_pkg::CL_ADD_SKIP)
                     && ((prev_cls_reg == tsd_pkg::CL_ADD_CARRY)
                     || (prev_cls_reg == tsd_pkg::CL_SUB_CARRY));
  assign ent_xfer = (ent_dec.cls == tsd_pkg::CL_BRANCH) || (ent_dec.cls == tsd_pkg::CL_CALL);
  // RQ17 even eight-bit operand
  assign cur_bad = ((cur_dec.cls == tsd_pkg::CL_MEM8) && ins_word[0])
                   || ((cur_dec.cls == tsd_pkg::CL_CALL_BLK)
                   && ({ins_pc[13:12], ins_word[11:0]} > tsd_pkg::ADDR_MAX));
  // RQ1 two-cycle entries only
  // RQ2 legal one-byte pairing
  assign ent_bad = (ent_dec.two_byte && !ent_xfer && (ent_dec.cyc != tsd_pkg::CYC_TWO))
                   || (!ent_dec.two_byte && (tbl_word[7:0] != 8'h00)
                   && !((ent_dec.cls == tsd_pkg::CL_PTR_MOV)
                   && (two_dec.cls == tsd_pkg::CL_PTR_STEP)
                   && pair_ok(ent_dec.pair, two_dec.tgt)))
                   || (ent_xfer && (tbl_word[13:0] > tsd_pkg::ADDR_MAX))
                   || ((ent_dec.cls == tsd_pkg::CL_MEM8) && tbl_word[0]);

  // ----------------------------------------
  // Machine cycle divider
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= 8'h00;
      mc_tick_reg <= 1'b0;
    end else if (div_reg == 8'(MC_DIV - 1)) begin
      div_reg <= 8'h00;
      mc_tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      mc_tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // History of executed instructions
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_grp_reg <= tsd_pkg::GRP_NONE;
      prev_cls_reg <= tsd_pkg::CL_OTHER;
    end else if (take) begin
      if (skip_pend_reg) begin
        last_grp_reg <= tsd_pkg::GRP_NONE;
        prev_cls_reg <= tsd_pkg::CL_OTHER;
      // RQ23 remember last group
      end else if (cur_dec.cls != tsd_pkg::CL_TREF && !stacked) begin
        last_grp_reg <= cur_dec.grp;
        prev_cls_reg <= cur_dec.cls;
      end
    end else if (state_reg == ST_TREAD && tbl_ack) begin
      // RQ7 entry group stays in force
      last_grp_reg <= ent_bad ? tsd_pkg::GRP_NONE : ent_dec.grp;
      prev_cls_reg <= ent_dec.cls;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      ins_ready_reg <= 1'b1;
      skip_pend_reg <= 1'b0;
      skip_left_reg <= 2'h0;
      in_tref_reg <= 1'b0;
      pend2_reg <= 1'b0;
      pair1_reg <= 2'h0;
      step_bytes_reg <= 2'h0;
      tbl_req_reg <= 1'b0;
      tbl_addr_reg <= 7'h00;
      ex_valid_reg <= 1'b0;
      ex_op_reg <= '0;
      op2_reg <= '0;
      pc_step_valid_reg <= 1'b0;
      pc_step_bytes_reg <= 2'h0;
      op_error_reg <= 1'b0;
    end else begin
      ex_valid_reg <= 1'b0;
      pc_step_valid_reg <= 1'b0;
      op_error_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (take) begin
            ins_ready_reg <= 1'b0;
            in_tref_reg <= (cur_dec.cls == tsd_pkg::CL_TREF) && !skip_pend_reg;
            if (skip_pend_reg) begin
              // RQ4 skip like any one-byte
              // RQ21 one machine cycle
              skip_pend_reg <= 1'b0;
              skip_left_reg <= (cur_dec.cls == tsd_pkg::CL_TREF) ? tsd_pkg::SKIP_MC_TREF :
                               cur_dec.two_byte ? tsd_pkg::SKIP_MC_2B : tsd_pkg::SKIP_MC_1B;
              step_bytes_reg <= cur_dec.two_byte ? 2'h2 : 2'h1;
              state_reg <= ST_SKIP;
            end else if (cur_dec.cls == tsd_pkg::CL_TREF) begin
              // RQ22 read the even entry
              tbl_req_reg <= 1'b1;
              tbl_addr_reg <= ins_word[14:8];
              state_reg <= ST_TREAD;
            end else if (stacked || cur_bad) begin
              // RQ8 later loads act as no-ops
              op_error_reg <= cur_bad;
              pc_step_valid_reg <= 1'b1;
              pc_step_bytes_reg <= cur_dec.two_byte ? 2'h2 : 2'h1;
              ins_ready_reg <= 1'b1;
            end else begin
              ex_op_reg <= make_op(cur_dec, ins_word, 1'b0, radix_cur);
              ex_valid_reg <= 1'b1;
              step_bytes_reg <= cur_dec.two_byte ? 2'h2 : 2'h1;
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_SKIP: begin
          if (mc_tick_reg) begin
            if (skip_left_reg == 2'h1) begin
              pc_step_valid_reg <= 1'b1;
              pc_step_bytes_reg <= step_bytes_reg;
              ins_ready_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              skip_left_reg <= skip_left_reg - 2'h1;
            end
          end
        end
        ST_TREAD: begin
          if (tbl_ack) begin
            tbl_req_reg <= 1'b0;
            // RQ3 only the reference byte counts
            step_bytes_reg <= 2'h1;
            if (ent_bad) begin
              op_error_reg <= 1'b1;
              pc_step_valid_reg <= 1'b1;
              pc_step_bytes_reg <= 2'h1;
              ins_ready_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              // RQ6 entry runs despite earlier group
              ex_op_reg <= make_op(ent_dec, tbl_word, 1'b1, radix_ent);
              ex_valid_reg <= 1'b1;
              pend2_reg <= !ent_dec.two_byte && (tbl_word[7:0] != 8'h00);
              op2_reg <= make_op(two_dec, {tbl_word[7:0], 8'h00}, 1'b1, 1'b0);
              pair1_reg <= ent_dec.pair;
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (ex_done) begin
            // RQ5 taken skip passes to next
            if (ex_cond && ex_op_reg.skip_en) begin
              skip_pend_reg <= 1'b1;
            end
            if (pend2_reg) begin
              pend2_reg <= 1'b0;
              ex_op_reg <= op2_reg;
              ex_valid_reg <= 1'b1;
            end else begin
              pc_step_valid_reg <= 1'b1;
              pc_step_bytes_reg <= step_bytes_reg;
              ins_ready_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign ins_ready = ins_ready_reg;
  assign tbl_req = tbl_req_reg;
  assign tbl_addr = tbl_addr_reg;
  assign ex_valid = ex_valid_reg;
  assign ex_op = ex_op_reg;
  assign pc_step_valid = pc_step_valid_reg;
  assign pc_step_bytes = pc_step_bytes_reg;
  assign op_error = op_error_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // A bad entry must never reach the execution unit, so it is dropped as an error.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_entry_two_cycle: // RQ1
  assert property (state_reg == ST_TREAD && tbl_ack && ent_dec.two_byte && !ent_xfer
                   && ent_dec.cyc != tsd_pkg::CYC_TWO |=> op_error_reg && !ex_valid_reg)
    else $error("Entry with wrong cycle count was issued.");

  a_pair_same_ptr: // RQ2
  assert property (ex_valid_reg && ex_op_reg.from_table
                   && ex_op_reg.cls == tsd_pkg::CL_PTR_STEP && $past(state_reg) == ST_EXEC
                   |-> pair_ok(pair1_reg, ex_op_reg.op[10:8]))
    else $error("Pointer step issued for a foreign pair.");

  a_tref_one_byte: // RQ3
  assert property (pc_step_valid_reg && in_tref_reg |-> pc_step_bytes_reg == 2'h1)
    else $error("Table reference advanced the counter by more than one byte.");

  a_tref_skip_one: // RQ21
  assert property (take && skip_pend_reg && cur_dec.cls == tsd_pkg::CL_TREF
                   |=> state_reg == ST_SKIP && skip_left_reg == 2'h1 && !tbl_req_reg)
    else $error("Skipped table reference did not take one machine cycle.");

  a_ref_skip_next: // RQ5
  assert property (state_reg == ST_EXEC && ex_done && ex_cond && ex_op_reg.skip_en
                   |=> skip_pend_reg && (ins_ready_reg || state_reg == ST_EXEC))
    else $error("Taken skip was lost.");

  a_stack_ref_run: // RQ6
  assert property (state_reg == ST_TREAD && tbl_ack && !ent_bad
                   && ent_dec.grp != tsd_pkg::GRP_NONE
                   |=> ex_valid_reg && last_grp_reg == $past(ent_dec.grp))
    else $error("Referenced group load was not executed.");

  a_stack_nop: // RQ8
  assert property (take && !skip_pend_reg && stacked
                   |=> !ex_valid_reg && pc_step_valid_reg && state_reg == ST_IDLE)
    else $error("Repeated group load was executed.");

  a_radix_noskip: // RQ10
  assert property (take && !skip_pend_reg && radix_cur
                   |=> ex_valid_reg && !ex_op_reg.skip_en && ex_op_reg.keep_carry)
    else $error("Radix tail add was allowed to skip.");

  a_taddr_even: // RQ16
  assert property (tbl_req_reg |-> !tbl_addr_reg[0] && tbl_addr_reg >= tsd_pkg::TBL_LO)
    else $error("Table read at an illegal address.");

endmodule // tsd_table_ref_decode

`default_nettype wire

// >>> testbench/tsd_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none

module tsd_prog_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Table read port
  input wire logic tbl_req,
  input wire logic [6:0] tbl_addr,
  output logic tbl_ack,
  output logic [15:0] tbl_word
);
  logic [1:0] wait_reg;
  logic slow_reg;

  function automatic logic [15:0] entry(input logic [6:0] a);
    case (a)
      7'h20: return 16'hc300;
      7'h24: return 16'h8700;
      7'h26: return 16'h8900;
      7'h28: return 16'h90a0;
      7'h2a: return 16'h90a3;
      7'h2c: return 16'he123;
      7'h2e: return 16'h0123;
      default: return 16'h8000;
    endcase
  endfunction

  // Quick and slow answers alternate; outside the ack cycle the word is garbage.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_reg <= 2'h1;
      slow_reg <= 1'b1;
      tbl_ack <= 1'b0;
      tbl_word <= 16'h0;
    end else if (tbl_ack) begin
      tbl_ack <= 1'b0;
      tbl_word <= ~tbl_word;
    end else if (tbl_req) begin
      if (wait_reg == 2'h0) begin
        tbl_ack <= 1'b1;
        tbl_word <= entry(tbl_addr);
        wait_reg <= slow_reg ? 2'h3 : 2'h1;
        slow_reg <= ~slow_reg;
      end else begin
        wait_reg <= wait_reg - 2'h1;
      end
    end
  end
endmodule // tsd_prog_mem
`default_nettype wire

// >>> testbench/table_ref_and_stack_instr_decode_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp) begin compares++; if ((act) !== (exp)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, act, exp); end end

module table_ref_and_stack_instr_decode_test;
  logic clk, reset, ins_valid, ins_ready, tbl_req, tbl_ack, ex_valid, ex_done, ex_cond;
  logic pc_step_valid, op_error, bank_enable_flag, cond_next;
  logic [15:0] ins_word, tbl_word;
  logic [13:0] ins_pc;
  logic [6:0] tbl_addr;
  logic [3:0] bank_select_reg, l_reg, h_reg;
  logic [1:0] pc_step_bytes;
  tsd_pkg::tsd_exop_t ex_op;
  logic [7:0] exp_q[$];
  int n_fail, compares, cycles;

  tsd_table_ref_decode #(.MC_DIV(1)) tsd_table_ref_decode_i (.clk(clk), .reset(reset),
    .ins_valid(ins_valid), .ins_word(ins_word), .ins_pc(ins_pc), .ins_ready(ins_ready),
    .tbl_req(tbl_req), .tbl_addr(tbl_addr), .tbl_ack(tbl_ack), .tbl_word(tbl_word),
    .ex_valid(ex_valid), .ex_op(ex_op), .ex_done(ex_done), .ex_cond(ex_cond),
    .bank_enable_flag(bank_enable_flag), .bank_select_reg(bank_select_reg), .l_reg(l_reg),
    .h_reg(h_reg), .pc_step_valid(pc_step_valid), .pc_step_bytes(pc_step_bytes),
    .op_error(op_error));
  tsd_prog_mem tsd_prog_mem_i (.clk(clk), .reset(reset), .tbl_req(tbl_req),
    .tbl_addr(tbl_addr), .tbl_ack(tbl_ack), .tbl_word(tbl_word));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Waits for the previous op to retire first.
  task automatic op(input logic [15:0] w, input logic c, input logic x,
                    input tsd_pkg::tsd_cls_t k, input logic [1:0] b, input logic er);
    if (er) exp_q.push_back(8'h60);
    if (x) exp_q.push_back({3'h1, k});
    exp_q.push_back({3'h2, 3'h0, b});
    @(posedge clk);
    while (ins_ready !== 1'b1) @(posedge clk);
    ins_valid <= 1'b1;
    ins_word <= w;
    ins_pc <= 14'($urandom_range(16255));
    bank_enable_flag <= 1'($urandom);
    bank_select_reg <= 4'($urandom);
    l_reg <= 4'($urandom);
    h_reg <= 4'($urandom);
    cond_next <= c;
    @(posedge clk);
    while (ins_ready !== 1'b1) @(posedge clk);
    ins_valid <= 1'b0;
  endtask

  task automatic take(input logic [7:0] act);
    logic [7:0] e;
    e = (exp_q.size() == 0) ? 8'hff : exp_q.pop_front();
    `CHK(act, e)
  endtask

  task automatic chk_op(input logic [15:0] w);
    logic [3:0] bk;
    bk = bank_enable_flag ? bank_select_reg : 4'h0;
    if (w[15:11] == 5'h1f) begin
      `CHK(ex_op.bit_fn, w[10:8])
      `CHK(ex_op.bit_num, (w[7:6] == tsd_pkg::BM_PL) ? l_reg[1:0] : w[5:4])
      unique case (w[7:6])
        tsd_pkg::BM_FB: `CHK(ex_op.bit_addr, {tsd_pkg::FMEM_FB, w[3:0]})
        tsd_pkg::BM_FF: `CHK(ex_op.bit_addr, {tsd_pkg::FMEM_FF, w[3:0]})
        tsd_pkg::BM_PL: `CHK(ex_op.bit_addr, {tsd_pkg::PMEM_TOP, w[3:0], l_reg[3:2]})
        default: `CHK(ex_op.bit_addr, {bk, h_reg, w[3:0]})
      endcase
    end
    if (w[15:8] == 8'hb3) `CHK(ex_op.pair_sel, w[2:0])
    if (w[15:11] == 5'h1e) `CHK(ex_op.target, {3'h0, w[10:0]})
    if (w[15:12] == 4'he) `CHK(ex_op.target, {ins_pc[13:12], w[11:0]})
  endtask

  // Stand-in execution unit: finishes each issued op three cycles later.
  initial begin
    ex_done = 1'b0;
    ex_cond = 1'b0;
    forever begin
      @(posedge clk);
      if (ex_valid === 1'b1) begin
        repeat (2) @(posedge clk);
        ex_done <= 1'b1;
        ex_cond <= cond_next;
        @(posedge clk);
        ex_done <= 1'b0;
        ex_cond <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (op_error === 1'b1) take(8'h60);
    if (tbl_req === 1'b1) `CHK(tbl_addr, ins_word[14:8])
    if (ex_valid === 1'b1) take({3'h1, ex_op.cls});
    if (ex_valid === 1'b1 && ins_word[15:13] != 3'h1) chk_op(ins_word);
    if (pc_step_valid === 1'b1) take({3'h2, 3'h0, pc_step_bytes});
    cycles++;
    if (cycles > 5000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    reset = 1'b1;
    ins_valid = 1'b0;
    ins_word = 16'h0;
    ins_pc = 14'h0;
    bank_enable_flag = 1'b0;
    bank_select_reg = 4'h0;
    l_reg = 4'h0;
    h_reg = 4'h0;
    cond_next = 1'b0;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    void'($urandom(49));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    op(16'h8500, 1'b0, 1'b1, tsd_pkg::CL_LD_A4, 2'h1, 1'b0);
    op(16'h8600, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h1, 1'b0);
    op(16'hb012, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h2, 1'b0);
    op(16'hb134, 1'b0, 1'b1, tsd_pkg::CL_LD_HL8, 2'h2, 1'b0);
    op(16'hb156, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h2, 1'b0);
    op(16'h2000, 1'b1, 1'b1, tsd_pkg::CL_ADD_SKIP, 2'h1, 1'b0);
    op(16'h8100, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h1, 1'b0);
    op(16'hc500, 1'b1, 1'b1, tsd_pkg::CL_ADD_SKIP, 2'h1, 1'b0);
    op(16'h2200, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h1, 1'b0);
    op(16'h8200, 1'b0, 1'b1, tsd_pkg::CL_LD_A4, 2'h1, 1'b0);
    op(16'h2400, 1'b0, 1'b1, tsd_pkg::CL_LD_A4, 2'h1, 1'b0);
    op(16'hc000, 1'b0, 1'b1, tsd_pkg::CL_ADD_SKIP, 2'h1, 1'b0);
    op(16'h2600, 1'b0, 1'b1, tsd_pkg::CL_LD_A4, 2'h1, 1'b0);
    op(16'h8a00, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h1, 1'b0);
    exp_q.push_back({3'h1, tsd_pkg::CL_PTR_MOV});
    op(16'h2800, 1'b0, 1'b1, tsd_pkg::CL_PTR_STEP, 2'h1, 1'b0);
    op(16'h2a00, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h1, 1'b1);
    op(16'h2c00, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h1, 1'b1);
    op(16'h2e00, 1'b0, 1'b1, tsd_pkg::CL_BRANCH, 2'h1, 1'b0);
    op(16'hd100, 1'b0, 1'b1, tsd_pkg::CL_SUB_CARRY, 2'h1, 1'b0);
    op(16'hc600, 1'b1, 1'b1, tsd_pkg::CL_ADD_SKIP, 2'h1, 1'b0);
    op(16'hd000, 1'b0, 1'b1, tsd_pkg::CL_ADD_CARRY, 2'h1, 1'b0);
    op(16'hc700, 1'b1, 1'b1, tsd_pkg::CL_ADD_SKIP, 2'h1, 1'b0);
    op(16'h8300, 1'b0, 1'b1, tsd_pkg::CL_LD_A4, 2'h1, 1'b0);
    op(16'hb203, 1'b0, 1'b0, tsd_pkg::CL_OTHER, 2'h2, 1'b1);
    op(16'hb204, 1'b0, 1'b1, tsd_pkg::CL_MEM8, 2'h2, 1'b0);
    for (int f = 0; f < 8; f++) begin
      op({5'h1f, f[2:0], 8'($urandom)}, 1'b0, 1'b1, tsd_pkg::CL_BIT, 2'h2, 1'b0);
    end
    op({8'hb3, 5'h0, 3'($urandom)}, 1'b0, 1'b1, tsd_pkg::CL_XPAIR, 2'h2, 1'b0);
    op({5'h1e, 11'($urandom)}, 1'b0, 1'b1, tsd_pkg::CL_CALL_FAST, 2'h2, 1'b0);
    op(16'he123, 1'b0, 1'b1, tsd_pkg::CL_CALL_BLK, 2'h2, 1'b0);
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk);
    `CHK(exp_q.size(), 0)
    stop_test();
  end
endmodule // table_ref_and_stack_instr_decode_test
`default_nettype wire
